// ==== sct_regs.svh ====
// sct_regs.svh: timing counts for the conversion timing controller.
// assumes: included by bare name wherever the counts are needed.
`ifndef SCT_REGS_SVH
`define SCT_REGS_SVH

// =============================================================
// conversion clock counts
// =============================================================
`define SCT_ACQ_CCLKS   3   // least acquisition window, conv_clk periods
`define SCT_CONV_CCLKS  18  // conversion length, conv_clk periods
`define SCT_SCLK_DIV    2   // serial clock divided by this for conv_clk
`define SCT_OSC_DIV     1   // system clocks per internal oscillator tick

`endif

// ==== sct_pkg.sv ====
// sct_pkg.sv: types shared by the conversion timing controller.
// assumes: nothing beyond a SystemVerilog compiler.
package sct_pkg;

    // =========================================================
    // phases and state record
    // =========================================================
    typedef enum logic [0:0]
    {
        SCT_SAMPLE  = 1'b0,
        SCT_CONVERT = 1'b1
    } sct_phase_t;

    typedef struct packed
    {
        sct_phase_t phase;
        logic [4:0] conv_cnt;   // conv_clk periods into the conversion
        logic [1:0] acq_cnt;    // conv_clk periods of acquisition seen
        logic       pending;    // start taken, waiting for the next edge with acquisition complete
        logic [7:0] osc_cnt;
        logic       sclk_prev;
        logic       sclk_half;  // divide-by-two phase of the serial clock
        logic       start_prev;
        logic       src_cfg;    // written setting: 1 = serial clock source
        logic       src_act;    // source in use for the current conversion
        logic       chan;
        logic       auto_prev;
        logic       done;
        logic       conv_clk;
    } sct_state_t;

endpackage

// ==== sct_conv_timing.sv ====
// sct_conv_timing.sv: conversion timing and channel sequencing of a SAR
// converter core, one system clock.
// assumes: SCLK and CONVERT_START_N are synchronous to CLK and are
// sampled; serial clock edges arrive no faster than every other CLK.
//
// Operation
// - internal oscillator clocks conversions unless serial clock is selected.
// - serial clock source is divided by two to form conv_clk.
// - oscillator runs except in deep power-down or serial clock source.
// - at least three conv_clk periods of sampling precede each conversion.
// - conversion takes 18 conv_clks; host sets up start 20 ns early.
// - unsynchronised start begins one conv_clk later, 19 in total.
// - manual channel or automatic alternation 0, 1 on two-input variant.
// - input captured at start and isolated for the whole conversion.
// - start strobe freezes hold; conversion begins on next conv_clk edge once three sampling periods have passed.
// - auto trigger restarts three conv_clks after end, 21 per cycle.
`timescale 1ns/1ps
`include "sct_regs.svh"

module sct_conv_timing
#(
    parameter int OSC_DIV = `SCT_OSC_DIV
)
(
    input  wire logic CLK,
    input  wire logic RST_N,
    input  wire logic SCLK,
    input  wire logic CONVERT_START_N,
    input  wire logic CFG_WR,
    input  wire logic CFG_SRC_SCLK,
    input  wire logic AUTO_TRIGGER,
    input  wire logic AUTO_CHAN,
    input  wire logic MAN_CHAN,
    input  wire logic DEEP_PD,
    output logic      OSC_RUN,
    output logic      CONV_CLK,
    output logic      HOLD,
    output logic      CONVERTING,
    output logic      CONV_DONE,
    output logic      CHANNEL
);

    // =========================================================
    // elaboration checks
    // =========================================================
    if (OSC_DIV < 1 || OSC_DIV > 256)
    begin : g_bad_div
        $error("OSC_DIV must lie in 1..256");
    end

    localparam logic [7:0] OSC_LAST = 8'(OSC_DIV - 1);
    localparam logic [4:0] CONV_LAST = 5'(`SCT_CONV_CCLKS - 1);
    localparam logic [1:0] ACQ_LAST = 2'(`SCT_ACQ_CCLKS - 1);

    sct_pkg::sct_state_t s_reg;
    sct_pkg::sct_state_t s_next;

    logic osc_run;
    logic osc_tick;
    logic sclk_rise;
    logic tick;
    logic start_fall;
    logic begin_conv;
    logic conv_end;

    // =========================================================
    // conversion clock sources
    // =========================================================
    // oscillator stopped while the serial clock drives conversions
    assign osc_run   = !DEEP_PD && !s_reg.src_act;
    assign osc_tick  = osc_run && (s_reg.osc_cnt == OSC_LAST);
    assign sclk_rise = SCLK && !s_reg.sclk_prev;
    // every second serial clock rise is one conv_clk edge
    assign tick = s_reg.src_act ? (sclk_rise && s_reg.sclk_half)
                                : osc_tick;
    assign start_fall = !CONVERT_START_N && s_reg.start_prev;
    // a start landing on an edge is seen at the next edge instead
    assign begin_conv = tick && (s_reg.phase == sct_pkg::SCT_SAMPLE)
                      && (s_reg.acq_cnt == ACQ_LAST)
                      && (s_reg.pending || AUTO_TRIGGER)
                      && !DEEP_PD;
    // last conv_clk of a conversion, where sampling resumes
    assign conv_end = tick && (s_reg.phase == sct_pkg::SCT_CONVERT)
                    && (s_reg.conv_cnt == CONV_LAST);

    // =========================================================
    // next state
    // =========================================================
    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.sclk_prev = SCLK;
        s_next.start_prev = CONVERT_START_N;
        if (sclk_rise && s_reg.src_act)
        begin
            s_next.sclk_half = !s_reg.sclk_half;
        end
        if (!osc_run || osc_tick)
        begin
            s_next.osc_cnt = 8'h00;
        end
        else
        begin
            s_next.osc_cnt = s_reg.osc_cnt + 8'h01;
        end
        if (tick)
        begin
            s_next.conv_clk = !s_reg.conv_clk;
        end
        if (CFG_WR)
        begin
            s_next.src_cfg = CFG_SRC_SCLK;
        end
        // source switches only between conversions, never mid-way
        if (s_reg.phase == sct_pkg::SCT_SAMPLE && !s_reg.pending)
        begin
            s_next.src_act = s_reg.src_cfg;
            if (s_reg.src_act != s_reg.src_cfg)
            begin
                s_next.sclk_half = 1'b0;
            end
        end
        // falling start edge freezes the sample, even on a conv_clk edge
        if (start_fall && s_reg.phase == sct_pkg::SCT_SAMPLE)
        begin
            s_next.pending = 1'b1;
        end
        if (DEEP_PD)
        begin
            // power-down aborts any conversion in flight
            s_next.phase = sct_pkg::SCT_SAMPLE;
            s_next.pending = 1'b0;
            s_next.acq_cnt = 2'h0;
            s_next.conv_cnt = 5'h00;
        end
        else if (begin_conv)
        begin
            s_next.phase = sct_pkg::SCT_CONVERT;
            s_next.pending = 1'b0;
            s_next.conv_cnt = 5'h00;
            s_next.auto_prev = AUTO_CHAN;
            if (!AUTO_CHAN)
            begin
                s_next.chan = MAN_CHAN;
            end
            else if (!s_reg.auto_prev)
            begin
                s_next.chan = 1'b0;
            end
            else
            begin
                s_next.chan = !s_reg.chan;
            end
        end
        else if (tick && s_reg.phase == sct_pkg::SCT_SAMPLE)
        begin
            if (s_reg.acq_cnt != ACQ_LAST)
            begin
                s_next.acq_cnt = s_reg.acq_cnt + 2'h1;
            end
        end
        else if (tick && s_reg.phase == sct_pkg::SCT_CONVERT)
        begin
            if (s_reg.conv_cnt == CONV_LAST)
            begin
                s_next.phase = sct_pkg::SCT_SAMPLE;
                s_next.acq_cnt = 2'h0;
                s_next.done = 1'b1;
            end
            else
            begin
                s_next.conv_cnt = s_reg.conv_cnt + 5'h01;
            end
        end
    end

    // =========================================================
    // state register
    // =========================================================
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s_reg <= '{phase: sct_pkg::SCT_SAMPLE, start_prev: 1'b1,
                       default: '0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // =========================================================
    // outputs
    // =========================================================
    assign OSC_RUN    = osc_run;
    assign CONV_CLK   = s_reg.conv_clk;
    assign CONVERTING = (s_reg.phase == sct_pkg::SCT_CONVERT);
    // inputs stay isolated from the freeze until the conversion ends
    assign HOLD       = CONVERTING || s_reg.pending;
    assign CONV_DONE  = s_reg.done;
    assign CHANNEL    = s_reg.chan;

    // =========================================================
    // checking helpers
    // =========================================================
    logic [5:0] h_conv_ticks;
    logic [5:0] h_acq_ticks;
    logic       h_done_seen;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            h_conv_ticks <= 6'h00;
            h_acq_ticks  <= 6'h00;
            h_done_seen  <= 1'b0;
        end
        else
        begin
            if (begin_conv)
            begin
                h_conv_ticks <= 6'h00;
            end
            else if (tick && CONVERTING)
            begin
                h_conv_ticks <= h_conv_ticks + 6'h01;
            end
            // restart on the end tick itself so no acquisition tick is lost
            if (conv_end || DEEP_PD)
            begin
                h_acq_ticks <= 6'h00;
                h_done_seen <= conv_end && !DEEP_PD;
            end
            else if (tick && !CONVERTING && h_acq_ticks != 6'h3f)
            begin
                h_acq_ticks <= h_acq_ticks + 6'h01;
            end
        end
    end

    // =========================================================
    // assertions
    // =========================================================
    a_osc_gating: assert property (@(posedge CLK) disable iff (!RST_N)
        (DEEP_PD || s_reg.src_act) |-> !OSC_RUN && !osc_tick)
        else $error("oscillator ticks while it must be stopped");

    a_sclk_halving: assert property (@(posedge CLK) disable iff (!RST_N)
        (tick && s_reg.src_act) |-> sclk_rise && s_reg.sclk_half
            ##1 !s_reg.sclk_half)
        else $error("serial clock conv_clk edge not on every second rise");

    a_conv_length: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(CONVERTING) && !$past(DEEP_PD) |-> h_conv_ticks == 6'd18)
        else $error("conversion not 18 conv_clk periods long");

    a_acq_window: assert property (@(posedge CLK) disable iff (!RST_N)
        (begin_conv && h_done_seen) |-> h_acq_ticks >= 6'd2
            ##1 CONVERTING)
        else $error("conversion began before the sampling window");

    a_hold_isolate: assert property (@(posedge CLK) disable iff (!RST_N)
        (HOLD && !DEEP_PD && !conv_end) |=> HOLD)
        else $error("inputs not isolated during conversion");

    a_start_edge: assert property (@(posedge CLK) disable iff (!RST_N)
        (start_fall && !CONVERTING && !s_reg.pending && !DEEP_PD)
            |=> HOLD)
        else $error("start strobe did not freeze the sample");

    a_auto_restart: assert property (@(posedge CLK) disable iff (!RST_N)
        (tick && !CONVERTING && AUTO_TRIGGER && !DEEP_PD
            && h_acq_ticks == 6'd2) |=> CONVERTING)
        else $error("auto trigger restart not three conv_clks after end");

    a_chan_alternate: assert property (@(posedge CLK) disable iff (!RST_N)
        (begin_conv && AUTO_CHAN && s_reg.auto_prev)
            |=> CHANNEL != $past(CHANNEL))
        else $error("automatic channel did not alternate");

    a_src_latched: assert property (@(posedge CLK) disable iff (!RST_N)
        CONVERTING && $past(CONVERTING) |-> $stable(s_reg.src_act))
        else $error("clock source changed inside a conversion");

endmodule

// ==== sct_host_model.sv ====
// sct_host_model.sv: serial host model driving SCLK and convert start.
// assumes: one system clock; start requests arrive as one-cycle pulses.
`timescale 1ns/1ps

module sct_host_model
(
    input  wire logic CLK,
    input  wire logic RST_N,
    input  wire logic SCLK_EN,
    input  wire logic START_REQ,
    output logic      SCLK,
    output logic      CONVERT_START_N
);
    // =========================================================
    // serial clock and strobe
    // =========================================================
    // sclk parks low when disabled; a 200 ns period stays inside 1 us
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            SCLK            <= 1'b0;
            CONVERT_START_N <= 1'b1;
        end
        else
        begin
            SCLK            <= SCLK_EN ? ~SCLK : 1'b0;
            CONVERT_START_N <= ~START_REQ;
        end
    end
endmodule

// ==== sct_tb.sv ====
// sct_tb.sv: self-checking bench for the conversion timing controller.
// assumes: design and host model compiled first; OSC_DIV set to 2.
`timescale 1ns/1ps

module testbench;
    // =========================================================
    // wiring, rows and counters
    // =========================================================
    typedef struct packed
    {
        logic       src;
        logic       man;
        logic [7:0] len;
    } sct_row_t;

    logic       clk, rst_n, sclk_en, start_req, cfg_wr, cfg_src;
    logic       auto_trig, auto_chan, man_chan, deep_pd, sclk, start_n;
    logic       osc_run, conv_clk, hold, converting, conv_done, channel;
    logic [7:0] outs;
    logic       c_prev;
    int         failures, compares, len, i;
    sct_row_t   rows [4] = '{'{1'b0, 1'b0, 8'h24}, '{1'b0, 1'b1, 8'h24},
                             '{1'b1, 1'b0, 8'h48}, '{1'b1, 1'b1, 8'h48}};

    assign outs = {2'h0, conv_clk, hold, converting, conv_done, channel,
                   osc_run};

    sct_conv_timing #(.OSC_DIV(2)) u_sct_conv_timing
    (
        .CLK(clk), .RST_N(rst_n), .SCLK(sclk), .CONVERT_START_N(start_n),
        .CFG_WR(cfg_wr), .CFG_SRC_SCLK(cfg_src), .AUTO_TRIGGER(auto_trig),
        .AUTO_CHAN(auto_chan), .MAN_CHAN(man_chan), .DEEP_PD(deep_pd),
        .OSC_RUN(osc_run), .CONV_CLK(conv_clk), .HOLD(hold),
        .CONVERTING(converting), .CONV_DONE(conv_done), .CHANNEL(channel)
    );

    sct_host_model u_sct_host_model
    (
        .CLK(clk), .RST_N(rst_n), .SCLK_EN(sclk_en), .START_REQ(start_req),
        .SCLK(sclk), .CONVERT_START_N(start_n)
    );

    // 10 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // =========================================================
    // shared tasks
    // =========================================================
    // inputs move 1 ns after the edge so sampling never races
    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one strobe must always be taken, even on a conv_clk edge
    task automatic convert(output int n_len);
        int n;
        n_len = 0;
        start_req = 1'b1;
        step();
        start_req = 1'b0;
        step();
        step();
        check("hold_taken", 8'h01, 8'(hold));
        for (n = 0; n < 40 && converting !== 1'b1; n++)
            step();
        while (converting === 1'b1 && n_len < 200)
        begin
            step();
            n_len++;
        end
        if (n == 40 || n_len == 200)
        begin
            failures++;
            tally_and_finish();
        end
    endtask

    task automatic write_src(input logic src);
        cfg_src = src;
        cfg_wr = 1'b1;
        step();
        cfg_wr = 1'b0;
    endtask

    // =========================================================
    // main sequence
    // =========================================================
    initial
    begin
        {rst_n, sclk_en, start_req, cfg_wr, cfg_src} = 5'h00;
        {auto_trig, auto_chan, man_chan, deep_pd} = 4'h0;
        failures = 0;
        compares = 0;
        repeat (4) step();
        check("reset_outs", 8'h01, outs);
        rst_n = 1'b1;
        // ordinary cases: clock source and manual channel per row
        for (i = 0; i < 4; i++)
        begin
            sclk_en = rows[i].src;
            man_chan = rows[i].man;
            write_src(rows[i].src);
            repeat (16) step();
            check("osc_run", 8'(!rows[i].src), 8'(osc_run));
            // one conv_clk period: two CLKs internal, two SCLK periods serial
            c_prev = conv_clk;
            repeat (rows[i].src ? 4 : 2) step();
            check("conv_clk", 8'(!c_prev), 8'(conv_clk));
            convert(len);
            check("conv_len", rows[i].len, 8'(len));
            check("done_hold", 8'h02, {6'h0, conv_done, hold});
            check("channel", {7'h0, rows[i].man}, {7'h0, channel});
            step();
            check("done_pulse", 8'h00, {7'h0, conv_done});
        end
        // source write and strobe while serial conversion is in flight
        fork
            convert(len);
            begin
                repeat (30) step();
                {cfg_src, cfg_wr, start_req} = 3'h3;
                step();
                {cfg_wr, start_req} = 2'h0;
            end
        join
        check("inflight_len", 8'h48, 8'(len));
        step();
        convert(len);
        check("next_len", 8'h24, 8'(len));
        // auto trigger with channel alternation, 21 ticks a cycle
        step();
        {auto_chan, auto_trig} = 2'h3;
        for (i = 0; i < 3; i++)
        begin
            for (len = 1; len < 100 && conv_done !== 1'b1; len++)
                step();
            if (len == 100)
            begin
                failures++;
                tally_and_finish();
            end
            check("auto_chan", {7'h0, i[0]}, {7'h0, channel});
            if (i > 0)
                check("auto_period", 8'h2a, 8'(len));
            step();
        end
        {auto_chan, auto_trig} = 2'h0;
        // deep power-down aborts a conversion with no done pulse
        repeat (8) step();
        fork
            convert(len);
            begin
                repeat (20) step();
                deep_pd = 1'b1;
            end
        join
        check("pd_outs", 8'h00, {5'h0, conv_done, hold, osc_run});
        check("pd_short", 8'h01, {7'h0, len < 36});
        deep_pd = 1'b0;
        step();
        tally_and_finish();
    end
endmodule
